// file: src/supervisor_map.svh
/*
  Register offsets, field positions, reset values and timing constants
  of the scan run/stop supervisor.
  Assumes a 25 MHz system clock and 32-bit AXI4-Lite words.
*/
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ 25000
`define TICK_TIME_MS 1
`define WDT_DEFAULT_MS 11'h0c8
`define WDT_MIN_MS 11'h00a
`define WDT_MAX_MS 11'h7d0
`define FLICKER_MS 11'h0fa

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_WDT 5'h04
`define REG_STATUS 5'h08
`define REG_CODE 5'h0c
`define REG_STEP 5'h10
`define REG_STEP_LATCHED 5'h14
`define REG_CLEAR 5'h18

// ----------------------------------------------------------------------
// Fields, reset values and codes
// ----------------------------------------------------------------------
`define CTRL_TOOL_STOP 0
`define CTRL_CONTACT_EN 1
`define CTRL_ERR_STOP 2
`define CTRL_RESET 3'h0
`define CLR_SELFDIAG 0
`define CLR_OPERR 1
`define CLR_OPERR_LATCHED 2
`define OPERR_CODE 16'h0032
`define WDT_ERR_CODE 16'h0016
`define INIT_ERR_CODE 16'h000a
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: src/supervisor_pkg.sv
/*
  Types shared by the scan run/stop supervisor and its surroundings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package supervisor_pkg;

  typedef enum logic [4:0] {
    st_init = 5'h01,
    st_stop = 5'h02,
    st_run = 5'h04,
    st_stopping = 5'h08,
    st_halt = 5'h10
  } run_state_type;

  typedef struct packed {
    logic end_of_scan;
    logic instr_valid;
    logic always_check;
    logic exec_cond;
    logic ref_fault;
    logic [15:0] step;
  } engine_event_type;

  typedef struct packed {
    logic run_enable;
    logic outputs_on;
    logic restart_step0;
    logic skip_step;
    logic run_lamp;
    logic first_scan_flag;
  } engine_ctrl_type;

endpackage

// file: src/scan_run_stop_supervisor.sv
/*
  Run/stop arbiter, scan watchdog and self-diagnostic handler for a
  scan-cycle sequence engine, with an AXI4-Lite register slave.
  Assumes the engine reports events synchronous to aclk and obeys the
  control word it is given.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
// Summary of operation
// RQ1 - Engine runs only while the terminal pair is shorted; opening stops.
// RQ2 - Remote stop finishes the current scan up to end, then stops.
// RQ3 - Remote run after remote stop restarts execution at step 0.
// RQ4 - With contact control, contact off means run, contact on means stop.
// RQ5 - A stop from any remote source wins over all others.
// RQ6 - Run resumes only after every stopping source is set back to run.
// RQ7 - Run repeats step 0 to end; stop halts and drives outputs off.
// RQ8 - Watchdog timeout is 200 ms after reset.
// RQ9 - Watchdog timeout is settable between 10 and 2000 ms.
// RQ10 - Watchdog count restarts after end-of-scan, before step 0.
// RQ11 - End not reached within the timeout raises a watchdog error.
// RQ12 - Watchdog error turns all outputs off at once.
// RQ13 - Watchdog error makes the run lamp flicker.
// RQ14 - Any self-diagnostic error sets the flag and stores its code.
// RQ15 - Diagnosis runs at reset, at each instruction and at end of scan.
// RQ16 - Load, logic, compare, output always checked; others when enabled.
// RQ17 - Stop-mode error halts, outputs off, other state kept.
// RQ18 - Continuation error skips the faulty part and goes on.
// RQ19 - A setting picks stop or continue on operation errors.
// RQ20 - Operation error: continue, flicker, two flags, two steps, code 50.
// RQ21 - First-scan flag is on for exactly one scan after stop to run.
// RQ22 - Watchdog counts millisecond ticks and compares with the timeout.
`include "supervisor_map.svh"
`timescale 1ns/1ns
`default_nettype none

module scan_run_stop_supervisor #(
  parameter int MS_CYCLES = `CLK_FREQ_KHZ * `TICK_TIME_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic run_terminal_pair,
  input wire logic remote_run_contact,
  input wire logic selfcheck_ok,
  input wire supervisor_pkg::engine_event_type engine_event,
  output supervisor_pkg::engine_ctrl_type engine_ctrl
);
  import supervisor_pkg::*;

  localparam int TW = $clog2(MS_CYCLES + 1);

  if (MS_CYCLES < 1) begin : g_bad_tick
    $error("MS_CYCLES must be at least one");
  end

  run_state_type state_reg, state_next;
  engine_ctrl_type engine_ctrl_reg, engine_ctrl_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [10:0] wdt_ms_reg, wdt_ms_next, ms_count_reg, ms_count_next;
  logic [10:0] blink_ms_reg, blink_ms_next;
  logic [TW-1:0] tick_reg, tick_next;
  logic blink_reg, blink_next, flicker_reg, flicker_next;
  logic selfdiag_flag_reg, selfdiag_flag_next;
  logic oper_flag_reg, oper_flag_next;
  logic oper_latched_reg, oper_latched_next;
  logic [15:0] code_reg, code_next, step_reg, step_next;
  logic [15:0] step_latched_reg, step_latched_next;
  logic tick, running, remote_stop, instr_err, wdt_expired;

  // --------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [4:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_word;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wr_hit = waddr_reg == `REG_CTRL || waddr_reg == `REG_WDT ||
             waddr_reg == `REG_CLEAR;
    for (int i = 0; i < 4; i++) begin
      wr_word[8*i +: 8] = wstrb_reg[i] ? wdata_reg[8*i +: 8] : 8'h00;
    end
    if (awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      unique case (araddr)
        `REG_CTRL: rdata_next = {29'h0, ctrl_reg};
        `REG_WDT: rdata_next = {21'h0, wdt_ms_reg};
        `REG_STATUS: rdata_next = {22'h0, state_reg, flicker_reg,
          oper_latched_reg, oper_flag_reg, selfdiag_flag_reg,
          engine_ctrl_reg.first_scan_flag};
        `REG_CODE: rdata_next = {16'h0, code_reg};
        `REG_STEP: rdata_next = {16'h0, step_reg};
        `REG_STEP_LATCHED: rdata_next = {16'h0, step_latched_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // --------------------------------------------------------------------
  // Supervisor state, watchdog and diagnostics
  // --------------------------------------------------------------------
  always_comb begin
    tick = tick_reg == TW'(MS_CYCLES - 1); // RQ22
    running = state_reg == st_run || state_reg == st_stopping;
    remote_stop = ctrl_reg[`CTRL_TOOL_STOP] ||
      (ctrl_reg[`CTRL_CONTACT_EN] && remote_run_contact); // RQ4 RQ5 RQ6
    instr_err = engine_event.instr_valid && engine_event.ref_fault &&
      (engine_event.always_check || engine_event.exec_cond); // RQ15 RQ16
    wdt_expired = running && ms_count_reg >= wdt_ms_reg; // RQ11 RQ22
    tick_next = tick ? '0 : tick_reg + TW'(1);
    blink_ms_next = blink_ms_reg;
    blink_next = blink_reg;
    if (tick) begin
      blink_ms_next = blink_ms_reg + 11'h001;
      if (blink_ms_reg == `FLICKER_MS) begin
        blink_ms_next = 11'h000;
        blink_next = !blink_reg;
      end
    end
    ms_count_next = ms_count_reg;
    if (tick && ms_count_reg != `WDT_MAX_MS) begin
      ms_count_next = ms_count_reg + 11'h001;
    end
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    wdt_ms_next = wdt_ms_reg;
    flicker_next = flicker_reg;
    selfdiag_flag_next = selfdiag_flag_reg;
    oper_flag_next = oper_flag_reg;
    oper_latched_next = oper_latched_reg;
    code_next = code_reg;
    step_next = step_reg;
    step_latched_next = step_latched_reg;
    engine_ctrl_next = engine_ctrl_reg;
    engine_ctrl_next.restart_step0 = 1'b0;
    engine_ctrl_next.skip_step = 1'b0;
    if (wr_fire && waddr_reg == `REG_CTRL) begin
      ctrl_next = wr_word[2:0]; // RQ19
    end
    if (wr_fire && waddr_reg == `REG_WDT && wr_word[10:0] >= `WDT_MIN_MS &&
        wr_word[10:0] <= `WDT_MAX_MS && wr_word[31:11] == 21'h0) begin
      wdt_ms_next = wr_word[10:0]; // RQ9
    end
    if (wr_fire && waddr_reg == `REG_CLEAR) begin
      if (wr_word[`CLR_SELFDIAG]) begin
        selfdiag_flag_next = 1'b0;
        flicker_next = 1'b0;
      end
      if (wr_word[`CLR_OPERR]) begin
        oper_flag_next = 1'b0;
      end
      if (wr_word[`CLR_OPERR_LATCHED]) begin
        oper_latched_next = 1'b0;
      end
    end
    unique case (state_reg)
      st_init: begin
        if (selfcheck_ok) begin
          state_next = st_stop;
        end else begin
          state_next = st_halt; // RQ15
          selfdiag_flag_next = 1'b1;
          code_next = `INIT_ERR_CODE;
        end
      end
      st_stop: begin
        if (run_terminal_pair && !remote_stop) begin
          state_next = st_run; // RQ3 RQ6
          engine_ctrl_next.restart_step0 = 1'b1;
          engine_ctrl_next.first_scan_flag = 1'b1; // RQ21
          ms_count_next = 11'h000;
        end
      end
      st_run, st_stopping: begin
        if (!run_terminal_pair) begin
          state_next = st_stop; // RQ1
        end else if (wdt_expired) begin
          state_next = st_halt; // RQ11 RQ12
          flicker_next = 1'b1; // RQ13
          selfdiag_flag_next = 1'b1; // RQ14
          code_next = `WDT_ERR_CODE;
        end else if (instr_err) begin
          selfdiag_flag_next = 1'b1; // RQ14 RQ20
          code_next = `OPERR_CODE;
          flicker_next = 1'b1;
          oper_flag_next = 1'b1;
          step_next = engine_event.step;
          if (!oper_latched_reg) begin
            oper_latched_next = 1'b1;
            step_latched_next = engine_event.step;
          end
          if (ctrl_reg[`CTRL_ERR_STOP]) begin
            state_next = st_halt; // RQ17
          end else begin
            engine_ctrl_next.skip_step = 1'b1; // RQ18
          end
        end else if (engine_event.end_of_scan) begin
          ms_count_next = 11'h000; // RQ10
          engine_ctrl_next.first_scan_flag = 1'b0; // RQ21
          if (state_reg == st_stopping) begin
            state_next = st_stop; // RQ2
          end else begin
            engine_ctrl_next.restart_step0 = 1'b1; // RQ7
          end
        end
        if (state_next == st_run && remote_stop) begin
          state_next = st_stopping; // RQ2 RQ5
        end
      end
      st_halt: begin
        if (!run_terminal_pair) begin
          state_next = st_stop;
        end
      end
    endcase
    engine_ctrl_next.run_enable = state_next == st_run ||
      state_next == st_stopping; // RQ7
    engine_ctrl_next.outputs_on = engine_ctrl_next.run_enable; // RQ12 RQ17
    if (!engine_ctrl_next.run_enable) begin
      engine_ctrl_next.first_scan_flag = 1'b0;
    end
    engine_ctrl_next.run_lamp = flicker_next ? blink_next :
      engine_ctrl_next.run_enable; // RQ13 RQ20
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= st_init;
      engine_ctrl_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
      wdt_ms_reg <= `WDT_DEFAULT_MS; // RQ8
      ms_count_reg <= 11'h000;
      blink_ms_reg <= 11'h000;
      tick_reg <= '0;
      blink_reg <= 1'b0;
      flicker_reg <= 1'b0;
      selfdiag_flag_reg <= 1'b0;
      oper_flag_reg <= 1'b0;
      oper_latched_reg <= 1'b0;
      code_reg <= 16'h0000;
      step_reg <= 16'h0000;
      step_latched_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      engine_ctrl_reg <= engine_ctrl_next;
      ctrl_reg <= ctrl_next;
      wdt_ms_reg <= wdt_ms_next;
      ms_count_reg <= ms_count_next;
      blink_ms_reg <= blink_ms_next;
      tick_reg <= tick_next;
      blink_reg <= blink_next;
      flicker_reg <= flicker_next;
      selfdiag_flag_reg <= selfdiag_flag_next;
      oper_flag_reg <= oper_flag_next;
      oper_latched_reg <= oper_latched_next;
      code_reg <= code_next;
      step_reg <= step_next;
      step_latched_reg <= step_latched_next;
    end
  end

  assign engine_ctrl = engine_ctrl_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_run;
    state_reg == st_stop && run_terminal_pair && !remote_stop;
  endsequence

  sequence s_started;
    engine_ctrl_reg.restart_step0 && engine_ctrl_reg.first_scan_flag;
  endsequence

  a_terminal_open: assert property ( // RQ1
    running && !run_terminal_pair |=> state_reg == st_stop &&
    !engine_ctrl_reg.outputs_on)
    else $error("terminal open did not stop");
  a_stop_waits_end: assert property ( // RQ2
    state_reg == st_stopping && run_terminal_pair && !wdt_expired &&
    !instr_err && !engine_event.end_of_scan |=> state_reg == st_stopping)
    else $error("remote stop left before end of scan");
  a_run_restart: assert property ( // RQ3
    s_enter_run |=> s_started ##1 !engine_ctrl_reg.restart_step0)
    else $error("run did not restart at step 0");
  a_remote_stop_wins: assert property ( // RQ5
    state_reg == st_run && run_terminal_pair && remote_stop |=>
    state_reg inside {st_stopping, st_stop, st_halt})
    else $error("remote stop ignored");
  a_outputs_off: assert property ( // RQ7
    !(state_reg inside {st_run, st_stopping}) |-> !engine_ctrl_reg.outputs_on)
    else $error("outputs on outside run");
  a_wdt_default: assert property ( // RQ8
    $past(state_reg) == st_init |-> wdt_ms_reg == `WDT_DEFAULT_MS)
    else $error("watchdog default wrong");
  a_wdt_range: assert property ( // RQ9
    wdt_ms_reg >= `WDT_MIN_MS && wdt_ms_reg <= `WDT_MAX_MS)
    else $error("watchdog setting out of range");
  a_wdt_restart: assert property ( // RQ10
    running && run_terminal_pair && !wdt_expired && !instr_err &&
    engine_event.end_of_scan |=> ms_count_reg == 11'h000)
    else $error("watchdog not restarted at end of scan");
  a_wdt_timeout: assert property ( // RQ11
    running && run_terminal_pair && wdt_expired |=> state_reg == st_halt &&
    selfdiag_flag_reg && code_reg == `WDT_ERR_CODE && flicker_reg)
    else $error("watchdog timeout not handled");
  a_operr_cont: assert property ( // RQ20
    running && run_terminal_pair && !wdt_expired && instr_err &&
    !ctrl_reg[`CTRL_ERR_STOP] |=> engine_ctrl_reg.skip_step &&
    code_reg == `OPERR_CODE && oper_flag_reg && oper_latched_reg)
    else $error("continuation error not handled");
  a_operr_stop: assert property ( // RQ17
    running && run_terminal_pair && !wdt_expired && instr_err &&
    ctrl_reg[`CTRL_ERR_STOP] |=> state_reg == st_halt &&
    !engine_ctrl_reg.outputs_on)
    else $error("stop-mode error did not halt");
  a_first_scan_once: assert property ( // RQ21
    engine_ctrl_reg.first_scan_flag && state_reg == st_run &&
    run_terminal_pair && !wdt_expired && !instr_err &&
    engine_event.end_of_scan |=> !engine_ctrl_reg.first_scan_flag)
    else $error("first scan flag outlived its scan");

endmodule
`default_nettype wire

// file: test/engine_model.sv
/*
  Behavioural model of the sequence engine that the supervisor controls.
  Assumes the bench sets scan length, hang and fault options as levels.
*/
`timescale 1ns/1ns
`default_nettype none

module engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire supervisor_pkg::engine_ctrl_type engine_ctrl,
  input wire logic [15:0] scan_len,
  input wire logic hang,
  input wire logic [15:0] fault_step,
  input wire logic fault_always,
  input wire logic fault_exec,
  output supervisor_pkg::engine_event_type engine_event
);
  import supervisor_pkg::*;
  logic [15:0] step_reg;
  logic wait_reg;

  // ----------------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------------
  // Idle cycles show a toggling step so nothing leans on a stale value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_reg <= 16'h0000;
      wait_reg <= 1'b1;
      engine_event <= '0;
    end else begin
      engine_event <= '0;
      engine_event.step <= ~engine_event.step;
      if (engine_ctrl.restart_step0) begin
        step_reg <= 16'h0000;
        wait_reg <= 1'b0;
      end else if (engine_ctrl.run_enable && !wait_reg && !hang) begin
        engine_event.instr_valid <= 1'b1;
        engine_event.step <= step_reg;
        engine_event.ref_fault <= (step_reg == fault_step);
        engine_event.always_check <= fault_always;
        engine_event.exec_cond <= fault_exec;
        if (step_reg == scan_len - 16'h0001) begin
          engine_event.end_of_scan <= 1'b1;
          wait_reg <= 1'b1;
        end else begin
          step_reg <= step_reg + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/scan_run_stop_supervisor_tb.sv
/*
  Self-checking bench for the scan run/stop supervisor.
  Assumes the engine model and a 4-cycle millisecond tick.
*/
`include "supervisor_map.svh"
`timescale 1ns/1ns
`default_nettype none

module scan_run_stop_supervisor_tb;
  import supervisor_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic run_terminal_pair = 1'b0;
  logic remote_run_contact = 1'b0;
  logic selfcheck_ok = 1'b1;
  logic hang = 1'b0;
  logic fault_always = 1'b0;
  logic fault_exec = 1'b0;
  logic [15:0] fault_step = 16'hffff;
  logic [15:0] scan_len = 16'h0014;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  engine_event_type engine_event;
  engine_ctrl_type engine_ctrl;
  int num_errors = 0;
  int compares = 0;
  int n_restart = 0;
  int n_skip = 0;
  int n0, n;

  always #20 aclk = ~aclk;

  scan_run_stop_supervisor #(.MS_CYCLES(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .run_terminal_pair(run_terminal_pair),
    .remote_run_contact(remote_run_contact), .selfcheck_ok(selfcheck_ok),
    .engine_event(engine_event), .engine_ctrl(engine_ctrl));

  engine_model engine_u (
    .aclk(aclk), .aresetn(aresetn), .engine_ctrl(engine_ctrl),
    .scan_len(scan_len), .hang(hang), .fault_step(fault_step),
    .fault_always(fault_always), .fault_exec(fault_exec),
    .engine_event(engine_event));

  always @(posedge aclk) begin
    if (engine_ctrl.restart_step0 === 1'b1) n_restart++;
    if (engine_ctrl.skip_step === 1'b1) n_skip++;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [31:0] v);
    bit got;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      got = bvalid;
    end while (!got);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [4:0] a);
    bit got;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      got = rvalid;
    end while (!got);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] mask,
                    input logic [31:0] exp, input string name);
    axi_read(a);
    chk(name, exp, d & mask);
  endtask

  // Only run_enable, outputs_on and first_scan_flag are compared.
  // It returns on a rising edge so that the next stimulus lands there.
  task automatic ctl(input logic [5:0] exp, input string name);
    chk(name, 32'(exp), 32'(engine_ctrl & 6'h31));
    @(posedge aclk);
  endtask

  task automatic settle(input int k);
    repeat (k) @(negedge aclk);
  endtask

  task automatic wait_end;
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (engine_event.end_of_scan !== 1'b1 && k < 500);
    chk("end of scan", 32'h1, 32'(k < 500));
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  // The whole sequence needs well under a thousand cycles; allow 20000.
  initial begin
    #(40 * 20000);
    num_errors++;
    test_done;
  end

  initial begin
    do_reset;
    rd(`REG_WDT, 32'h7ff, {21'h0, `WDT_DEFAULT_MS}, "wdt reset");
    rd(`REG_CTRL, 32'h7, 32'h0, "ctrl reset");
    rd(`REG_STATUS, 32'h3e0, 32'h40, "state open pair");
    axi_read(5'h1c);
    chk("unmapped resp", 32'(`RESP_SLVERR), 32'(r));
    axi_write(`REG_WDT, 32'h9);
    chk("wdt low resp", 32'(`RESP_OKAY), 32'(r));
    rd(`REG_WDT, 32'h7ff, {21'h0, `WDT_DEFAULT_MS}, "wdt low");
    axi_write(`REG_WDT, 32'h7d1);
    rd(`REG_WDT, 32'h7ff, {21'h0, `WDT_DEFAULT_MS}, "wdt high");
    axi_write(`REG_WDT, {21'h0, `WDT_MAX_MS});
    rd(`REG_WDT, 32'h7ff, {21'h0, `WDT_MAX_MS}, "wdt max");
    axi_write(`REG_WDT, {21'h0, `WDT_MIN_MS});
    rd(`REG_WDT, 32'h7ff, {21'h0, `WDT_MIN_MS}, "wdt min");
    $display("register test done");
    run_terminal_pair <= 1'b1;
    settle(3);
    ctl(6'h31, "run start");
    n0 = n_restart;
    wait_end;
    settle(2);
    ctl(6'h30, "second scan");
    chk("scan restart", 32'(n0 + 1), 32'(n_restart));
    repeat (8) wait_end;
    settle(1);
    ctl(6'h30, "long run");
    run_terminal_pair <= 1'b0;
    settle(2);
    ctl(6'h00, "pair open");
    $display("run test done");
    run_terminal_pair <= 1'b1;
    remote_run_contact <= 1'b1;
    wait_end;
    axi_write(`REG_CTRL, 32'h3);
    rd(`REG_STATUS, 32'h3e0, 32'h100, "stopping");
    wait_end;
    settle(2);
    ctl(6'h00, "remote stop");
    axi_write(`REG_CTRL, 32'h2);
    settle(10);
    ctl(6'h00, "contact holds");
    n0 = n_restart;
    remote_run_contact <= 1'b0;
    settle(3);
    ctl(6'h31, "remote run");
    chk("restart on run", 32'(n0 + 1), 32'(n_restart));
    remote_run_contact <= 1'b1;
    wait_end;
    settle(2);
    ctl(6'h00, "contact stop");
    remote_run_contact <= 1'b0;
    settle(3);
    ctl(6'h31, "contact run");
    $display("remote test done");
    wait_end;
    hang <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (engine_ctrl.outputs_on === 1'b1 && n < 100);
    chk("wdt window", 32'h1, 32'(n >= 34 && n <= 50));
    rd(`REG_STATUS, 32'h12, 32'h12, "wdt flags");
    rd(`REG_CODE, 32'hffff, {16'h0, `WDT_ERR_CODE}, "wdt code");
    hang <= 1'b0;
    run_terminal_pair <= 1'b0;
    axi_write(`REG_CLEAR, 32'h1);
    rd(`REG_STATUS, 32'h12, 32'h0, "cleared");
    $display("watchdog test done");
    fault_step <= 16'h0003;
    run_terminal_pair <= 1'b1;
    repeat (2) wait_end;
    rd(`REG_STATUS, 32'hc, 32'h0, "unchecked");
    n0 = n_skip;
    fault_exec <= 1'b1;
    repeat (2) wait_end;
    settle(1);
    ctl(6'h30, "continue");
    chk("skip", 32'h1, 32'(n_skip > n0));
    rd(`REG_STATUS, 32'h1c, 32'h1c, "op flags");
    rd(`REG_CODE, 32'hffff, {16'h0, `OPERR_CODE}, "op code");
    fault_exec <= 1'b0;
    fault_always <= 1'b1;
    fault_step <= 16'h0005;
    repeat (2) wait_end;
    rd(`REG_STEP, 32'hffff, 32'h5, "error step");
    rd(`REG_STEP_LATCHED, 32'hffff, 32'h3, "latched step");
    axi_write(`REG_CTRL, 32'h4);
    settle(30);
    ctl(6'h00, "stop mode");
    rd(`REG_STATUS, 32'h3e0, 32'h200, "halt");
    $display("operation error test done");
    selfcheck_ok <= 1'b0;
    do_reset;
    rd(`REG_STATUS, 32'h3e2, 32'h202, "selfcheck fail");
    rd(`REG_CODE, 32'hffff, {16'h0, `INIT_ERR_CODE}, "init code");
    $display("selfcheck test done");
    test_done;
  end
endmodule
`default_nettype wire
